// >>> hw/rsw_glitch_filter.sv
`timescale 1ns/1ps

// ****************************************************************
// per-bit synchroniser and stability filter
// ****************************************************************
module rsw_glitch_filter #(
    parameter int              WIDTH      = 4,
    parameter int              FILTER_CYC = 5,
    parameter logic [WIDTH-1:0] INIT      = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] rawIn,
    output logic      [WIDTH-1:0] cleanOut
);

    localparam int CW = $clog2(FILTER_CYC + 1);

    // whole state of the filter bank
    typedef struct packed {
        logic [WIDTH-1:0]         meta;   // first flop, read by sync only
        logic [WIDTH-1:0]         sync;   // second flop
        logic [WIDTH-1:0]         clean;  // accepted level
        logic [WIDTH-1:0][CW-1:0] cnt;    // stable-cycle counters
    } rsw_filt_s;

    rsw_filt_s filt_q;
    rsw_filt_s filt_d;

    // next state: a level is taken only after it stood still
    // long enough, so short pulses never reach the supervisor
    always_comb
    begin
        filt_d      = filt_q;
        filt_d.meta = rawIn;
        filt_d.sync = filt_q.meta;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (filt_q.sync == filt_q.clean ? 1'b1 : 1'b0)
            begin
                filt_d.cnt[i] = filt_q.cnt[i];
            end
            if (filt_q.sync[i] == filt_q.clean[i])
            begin
                // level agrees, restart the count
                filt_d.cnt[i] = '0;
            end
            else if (filt_q.cnt[i] == CW'(FILTER_CYC - 1))
            begin
                // stood long enough, accept it
                filt_d.clean[i] = filt_q.sync[i];
                filt_d.cnt[i]   = '0;
            end
            else
            begin
                filt_d.cnt[i] = filt_q.cnt[i] + CW'(1);
            end
        end
    end

    // registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            filt_q       <= '0;
            filt_q.meta  <= INIT;
            filt_q.sync  <= INIT;
            filt_q.clean <= INIT;
        end
        else
        begin
            filt_q <= filt_d;
        end
    end

    assign cleanOut = filt_q.clean;

endmodule

// >>> hw/rsw_pkg.sv
// ****************************************************************
// shared constants and carriers of the reset supervisor
// ****************************************************************
package rsw_pkg;

    // clock figures
    localparam int CLK_PERIOD_NS     = 40;

    // reset hold times, as printed
    localparam int RST_HOLD_SHORT_NS = 500_000;      // about 0.5 ms
    localparam int RST_HOLD_LONG_NS  = 200_000_000;  // about 0.2 s
    // least times, so round up
    localparam int HOLD_SHORT_CYC    =
        (RST_HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_LONG_CYC     =
        (RST_HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // capacitor hold, in capacitor oscillator periods
    localparam int RT_CAP_HOLD_TICKS = 64;

    // watchdog periods, in watchdog clock cycles
    localparam int WD_TIMEOUT_INT    = 8193;
    localparam int WD_UPPER_INT      = WD_TIMEOUT_INT - 1;
    localparam int WD_LOWER_INT      = WD_TIMEOUT_INT / 32;
    localparam int WD_TIMEOUT_EXT    = 129;
    localparam int WD_UPPER_EXT      = 128;
    localparam int WD_LOWER_EXT      = 5;
    // internal watchdog boundaries, as printed
    localparam int WD_LOWER_INT_NS   = 50_000_000;    // about 50 ms
    localparam int WD_UPPER_INT_NS   = 1_600_000_000; // about 1.6 s
    // one internal watchdog clock, longest time so round down
    localparam int WD_INT_TICK_CYC   =
        WD_UPPER_INT_NS / (CLK_PERIOD_NS * WD_TIMEOUT_INT);

    // glitch filter, least time so round up
    localparam int GLITCH_NS         = 200;
    localparam int GLITCH_CYC        =
        (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter widths
    localparam int HOLD_W            = 23;
    localparam int WD_W              = 14;
    localparam int PRE_W             = 13;

    // strap codes of the timing pins
    localparam logic [1:0] STRAP_OPEN = 2'h0;
    localparam logic [1:0] STRAP_BIAS = 2'h1;
    localparam logic [1:0] STRAP_CAP  = 2'h2;

    // bit positions in the filtered input vector
    localparam int IDX_SENSE  = 0;
    localparam int IDX_OVER   = 1;
    localparam int IDX_UNDER  = 2;
    localparam int IDX_LOCK   = 3;
    localparam int IDX_KICK   = 4;
    localparam int IDX_RTOSC  = 5;
    localparam int IDX_WTOSC  = 6;
    localparam int IDX_RTSTR  = 7;
    localparam int IDX_WTSTR  = 9;
    localparam int NUM_IN     = 11;
    // lockout assumed until the comparator says otherwise
    localparam logic [NUM_IN-1:0] FILTER_INIT = 11'h008;

    // supervisor states
    typedef enum logic [1:0] {
        ST_LOCKOUT,
        ST_FAULT,
        ST_HOLD,
        ST_RUN
    } rsw_state_e;

    // analog comparator results
    typedef struct packed {
        logic vinLockout;   // input supply under lockout
        logic voutUnder;    // regulated output under window
        logic voutOver;     // regulated output over window
        logic resetSense;   // sense input above threshold
    } rsw_cond_s;

    // strap state of the two timing pins
    typedef struct packed {
        logic [1:0] watchdogTimingPin;
        logic [1:0] resetTimingPin;
    } rsw_strap_s;

endpackage

// >>> hw/rsw_supervisor.sv
`timescale 1ns/1ps

// Function
// - reset low on low sense or bad output
// - hold reset after faults clear, then release
// - open reset timing pin gives short hold
// - reset timing pin on rail: long hold
// - short glitches on inputs are filtered out
// - supply lockout holds reset low always
// - hold count waits for lockout to end
// - in-range load transients are no fault
// - early or missing kick trips a reset
// - after watchdog hold, watchdog restarts at zero
// - watchdog cleared while reset is low
// - upper boundary one tick before timeout
// - internal timeout is 8193 watchdog ticks
// - capacitor timeout 129 ticks, upper at 128
// - capacitor lower boundary at tick five
// - internal lower boundary is timeout over 32
// - rail strap gives about 50 ms, 1.6 s
// - capacitor strap clocks watchdog from capacitor
module rsw_supervisor #(
    parameter int HOLD_SHORT_CYC    = rsw_pkg::HOLD_SHORT_CYC,
    parameter int HOLD_LONG_CYC     = rsw_pkg::HOLD_LONG_CYC,
    parameter int RT_CAP_HOLD_TICKS = rsw_pkg::RT_CAP_HOLD_TICKS,
    parameter int WD_INT_TICK_CYC   = rsw_pkg::WD_INT_TICK_CYC,
    parameter int FILTER_CYC        = rsw_pkg::GLITCH_CYC
) (
    input  wire logic               sys_clk,
    input  wire logic               srst,
    input  wire rsw_pkg::rsw_cond_s  supplyCond,
    input  wire logic               watchdogKickInput,
    input  wire rsw_pkg::rsw_strap_s timingStrap,
    input  wire logic               resetTimingOsc,
    input  wire logic               watchdogTimingOsc,
    output logic                    systemResetNO,
    output logic                    systemResetNOe,
    output logic                    watchdogTrip
);

    // ************************************************************
    // state
    // ************************************************************

    // whole state of the supervisor
    typedef struct packed {
        rsw_pkg::rsw_state_e         state;     // supervisor phase
        logic [1:0]                  rtMode;    // reset timing strap
        logic [1:0]                  wtMode;    // watchdog strap
        logic [rsw_pkg::HOLD_W-1:0]  holdCnt;   // hold time count
        logic [rsw_pkg::WD_W-1:0]    wdCnt;     // watchdog ticks
        logic [rsw_pkg::PRE_W-1:0]   preCnt;    // internal prescaler
        logic                        kickPrev;  // kick level before
        logic                        rtOscPrev; // reset osc before
        logic                        wtOscPrev; // watchdog osc before
        logic                        rstOe;     // pulling line low
        logic                        rstO;      // pin data, always 0
        logic                        trip;      // watchdog trip pulse
    } rsw_sup_s;

    rsw_sup_s sup_q;
    rsw_sup_s sup_d;

    // ************************************************************
    // input conditioning
    // ************************************************************

    logic [rsw_pkg::NUM_IN-1:0] rawIn;   // all asynchronous pins
    logic [rsw_pkg::NUM_IN-1:0] fltIn;   // synced and filtered

    // every pin, straps and oscillators too, crosses here
    assign rawIn = {timingStrap.watchdogTimingPin,
                    timingStrap.resetTimingPin,
                    watchdogTimingOsc,
                    resetTimingOsc,
                    watchdogKickInput,
                    supplyCond.vinLockout,
                    supplyCond.voutUnder,
                    supplyCond.voutOver,
                    supplyCond.resetSense};

    // glitch filter on every monitored input
    rsw_glitch_filter #(
        .WIDTH      (rsw_pkg::NUM_IN),
        .FILTER_CYC (FILTER_CYC),
        .INIT       (rsw_pkg::FILTER_INIT)
    ) u_filter (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .rawIn    (rawIn),
        .cleanOut (fltIn)
    );

    logic fSense;      // sense input above threshold
    logic fOver;       // output above window
    logic fUnder;      // output below window
    logic fLock;       // input supply under lockout
    logic fKick;       // kick level
    logic fRtOsc;      // reset timing oscillator
    logic fWtOsc;      // watchdog timing oscillator

    assign fSense = fltIn[rsw_pkg::IDX_SENSE];
    assign fOver  = fltIn[rsw_pkg::IDX_OVER];
    assign fUnder = fltIn[rsw_pkg::IDX_UNDER];
    assign fLock  = fltIn[rsw_pkg::IDX_LOCK];
    assign fKick  = fltIn[rsw_pkg::IDX_KICK];
    assign fRtOsc = fltIn[rsw_pkg::IDX_RTOSC];
    assign fWtOsc = fltIn[rsw_pkg::IDX_WTOSC];

    // ************************************************************
    // timing decode
    // ************************************************************

    // hold length in ticks of the selected reset source
    function automatic logic [rsw_pkg::HOLD_W-1:0] holdLimit(
        input logic [1:0] mode
    );
        unique case (mode)
            rsw_pkg::STRAP_BIAS:
                holdLimit = rsw_pkg::HOLD_W'(HOLD_LONG_CYC);
            rsw_pkg::STRAP_CAP:
                holdLimit = rsw_pkg::HOLD_W'(RT_CAP_HOLD_TICKS);
            default:
                holdLimit = rsw_pkg::HOLD_W'(HOLD_SHORT_CYC);
        endcase
    endfunction

    // watchdog timeout in watchdog ticks
    function automatic logic [rsw_pkg::WD_W-1:0] wdTimeout(
        input logic [1:0] mode
    );
        if (mode == rsw_pkg::STRAP_CAP)
            wdTimeout = rsw_pkg::WD_W'(rsw_pkg::WD_TIMEOUT_EXT);
        else
            wdTimeout = rsw_pkg::WD_W'(rsw_pkg::WD_TIMEOUT_INT);
    endfunction

    // watchdog lower boundary in watchdog ticks
    function automatic logic [rsw_pkg::WD_W-1:0] wdLower(
        input logic [1:0] mode
    );
        if (mode == rsw_pkg::STRAP_CAP)
            wdLower = rsw_pkg::WD_W'(rsw_pkg::WD_LOWER_EXT);
        else
            wdLower = rsw_pkg::WD_W'(rsw_pkg::WD_LOWER_INT);
    endfunction

    logic                       faultNow;  // output or sense fault
    logic                       rtTick;    // reset timing enable
    logic                       wdTick;    // watchdog clock enable
    logic                       wdEnable;  // watchdog strapped on
    logic                       kickFall;  // falling kick edge
    logic [rsw_pkg::HOLD_W-1:0] holdEnd;   // hold length
    logic [rsw_pkg::WD_W-1:0]   wdEnd;     // timeout length
    logic [rsw_pkg::WD_W-1:0]   wdLow;     // lower boundary

    // only window comparator results count as output faults,
    // so in-range load steps never start a reset
    assign faultNow = !fSense || fOver || fUnder;

    // strap-selected clock enables for the shared counters
    assign rtTick   = (sup_q.rtMode == rsw_pkg::STRAP_CAP)
                    ? (fRtOsc && !sup_q.rtOscPrev) : 1'b1;
    assign wdTick   = (sup_q.wtMode == rsw_pkg::STRAP_CAP)
                    ? (fWtOsc && !sup_q.wtOscPrev)
                    : (sup_q.preCnt ==
                       rsw_pkg::PRE_W'(WD_INT_TICK_CYC - 1));
    assign wdEnable = (sup_q.wtMode == rsw_pkg::STRAP_BIAS)
                   || (sup_q.wtMode == rsw_pkg::STRAP_CAP);
    assign kickFall = sup_q.kickPrev && !fKick;
    assign holdEnd  = holdLimit(sup_q.rtMode);
    assign wdEnd    = wdTimeout(sup_q.wtMode);
    assign wdLow    = wdLower(sup_q.wtMode);

    // ************************************************************
    // supervisor sequence
    // ************************************************************

    // next state; lockout beats faults, faults beat the watchdog
    always_comb
    begin
        sup_d           = sup_q;
        sup_d.kickPrev  = fKick;
        sup_d.rtOscPrev = fRtOsc;
        sup_d.wtOscPrev = fWtOsc;
        sup_d.rstO      = 1'b0;
        sup_d.trip      = 1'b0;
        unique case (sup_q.state)
            rsw_pkg::ST_LOCKOUT:
            begin
                // straps are followed only while in lockout
                sup_d.rtMode  = fltIn[rsw_pkg::IDX_RTSTR +: 2];
                sup_d.wtMode  = fltIn[rsw_pkg::IDX_WTSTR +: 2];
                sup_d.holdCnt = '0;
                if (!fLock)
                    sup_d.state = faultNow ? rsw_pkg::ST_FAULT
                                           : rsw_pkg::ST_HOLD;
            end
            rsw_pkg::ST_FAULT:
            begin
                sup_d.holdCnt = '0;
                if (fLock)
                    sup_d.state = rsw_pkg::ST_LOCKOUT;
                else if (!faultNow)
                    sup_d.state = rsw_pkg::ST_HOLD;
            end
            rsw_pkg::ST_HOLD:
            begin
                if (fLock)
                    sup_d.state = rsw_pkg::ST_LOCKOUT;
                else if (faultNow)
                    sup_d.state = rsw_pkg::ST_FAULT;
                else if (rtTick)
                begin
                    if (sup_q.holdCnt >= holdEnd - 1'b1)
                    begin
                        // hold done, release and start watchdog
                        sup_d.state   = rsw_pkg::ST_RUN;
                        sup_d.holdCnt = '0;
                    end
                    else
                    begin
                        sup_d.holdCnt = sup_q.holdCnt + 1'b1;
                    end
                end
                if (fLock || faultNow)
                    sup_d.holdCnt = '0;
            end
            rsw_pkg::ST_RUN:
            begin
                if (fLock)
                    sup_d.state = rsw_pkg::ST_LOCKOUT;
                else if (faultNow)
                    sup_d.state = rsw_pkg::ST_FAULT;
                else if (wdEnable)
                begin
                    // internal prescaler wraps on each tick
                    if (wdTick)
                        sup_d.preCnt = '0;
                    else
                        sup_d.preCnt = sup_q.preCnt + 1'b1;
                    if (kickFall)
                    begin
                        // early or at the upper boundary: trip
                        if (sup_q.wdCnt < wdLow ||
                            sup_q.wdCnt >= wdEnd - 1'b1)
                            sup_d.trip = 1'b1;
                        else
                        begin
                            sup_d.wdCnt  = '0;
                            sup_d.preCnt = '0;
                        end
                    end
                    else if (wdTick)
                    begin
                        // reaching the timeout asserts reset
                        if (sup_q.wdCnt == wdEnd - 1'b1)
                            sup_d.trip = 1'b1;
                        else
                            sup_d.wdCnt = sup_q.wdCnt + 1'b1;
                    end
                end
                if (sup_d.trip)
                begin
                    sup_d.state   = rsw_pkg::ST_HOLD;
                    sup_d.holdCnt = '0;
                end
            end
        endcase
        // any way out of run, fault too, clears the watchdog
        if (sup_d.state != rsw_pkg::ST_RUN)
        begin
            sup_d.wdCnt  = '0;
            sup_d.preCnt = '0;
        end
        // line is pulled low in every state but run
        sup_d.rstOe = (sup_d.state != rsw_pkg::ST_RUN);
    end

    // registers; reset holds the line low, safe for the host
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sup_q       <= '0;
            sup_q.state <= rsw_pkg::ST_LOCKOUT;
            sup_q.rstOe <= 1'b1;
        end
        else
        begin
            sup_q <= sup_d;
        end
    end

    // outputs straight from flops; line only ever pulled low
    assign systemResetNO  = sup_q.rstO;
    assign systemResetNOe = sup_q.rstOe;
    assign watchdogTrip   = sup_q.trip;

    // ************************************************************
    // checks
    // ************************************************************

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_fault_pulls_low:
    assert property ((faultNow && sup_q.state == rsw_pkg::ST_RUN)
                     |=> systemResetNOe && !watchdogTrip)
        else $error("fault did not pull reset low");

    a_lockout_holds_low:
    assert property (fLock |=> systemResetNOe
                     && sup_q.state == rsw_pkg::ST_LOCKOUT)
        else $error("lockout did not hold reset low");

    a_lockout_no_count:
    assert property (sup_q.state == rsw_pkg::ST_LOCKOUT
                     |-> sup_q.holdCnt == '0)
        else $error("hold counted during lockout");

    a_release_after_hold:
    assert property ((sup_q.state == rsw_pkg::ST_HOLD && !fLock
                      && !faultNow && rtTick
                      && sup_q.holdCnt == holdEnd - 1'b1)
                     |=> !systemResetNOe && sup_q.wdCnt == '0)
        else $error("reset not released after hold");

    a_release_needs_hold:
    assert property ($fell(systemResetNOe)
                     |-> $past(sup_q.holdCnt) == holdEnd - 1'b1)
        else $error("reset released before hold ended");

    a_early_kick_trips:
    assert property ((sup_q.state == rsw_pkg::ST_RUN && wdEnable
                      && !fLock && !faultNow && kickFall
                      && sup_q.wdCnt < wdLow)
                     |=> watchdogTrip && systemResetNOe
                         ##1 !watchdogTrip)
        else $error("early kick did not trip");

    a_timeout_trips:
    assert property ((sup_q.state == rsw_pkg::ST_RUN && wdEnable
                      && !fLock && !faultNow && !kickFall && wdTick
                      && sup_q.wdCnt == wdEnd - 1'b1)
                     |=> watchdogTrip
                         && sup_q.state == rsw_pkg::ST_HOLD)
        else $error("timeout did not trip");

    a_wd_cleared_low:
    assert property (systemResetNOe |-> sup_q.wdCnt == '0)
        else $error("watchdog counted while reset low");

    a_wd_restart_zero:
    assert property ($rose(sup_q.state == rsw_pkg::ST_RUN)
                     |-> sup_q.wdCnt == '0 && sup_q.preCnt == '0)
        else $error("watchdog did not restart from zero");

    a_ext_window:
    assert property (sup_q.wtMode == rsw_pkg::STRAP_CAP
                     |-> wdLow == 14'h0005 && wdEnd == 14'h0081)
        else $error("capacitor watchdog window wrong");

endmodule

// >>> verif/rsw_host_model.sv
`timescale 1ns/1ps

// ****************************************************************
// supervised processor: kicks and sees the line
// ****************************************************************
module rsw_host_model (
    input  wire logic        sys_clk,
    input  wire logic        systemResetNOe,
    input  wire logic [15:0] kickGap,
    output logic             watchdogKickInput,
    output logic             resetLine
);
    logic [15:0] cnt = 16'h0; // cycles since last kick

    // pull-up: line high unless the device pulls it
    assign resetLine = systemResetNOe ? 1'b0 : 1'b1;

    // a processor held in reset restarts its schedule
    always @(negedge sys_clk)
    begin
        if (!resetLine || kickGap == 16'h0 || cnt >= kickGap - 16'h1)
            cnt <= 16'h0;
        else
            cnt <= cnt + 16'h1;
    end

    // low for the last 8 cycles: longer than the filter
    assign watchdogKickInput =
        !(kickGap != 16'h0 && cnt >= kickGap - 16'h8);
endmodule

// >>> verif/rsw_supervisor_tb_top.sv
`timescale 1ns/1ps

// ****************************************************************
// bench of the reset supervisor
// ****************************************************************
module rsw_supervisor_tb_top;
    logic                sys_clk = 1'b0;
    logic                srst = 1'b1;
    rsw_pkg::rsw_cond_s  cond = 4'h9;   // comparator pins
    rsw_pkg::rsw_strap_s strap = 4'h0;  // timing straps
    logic [15:0]         gap = 16'h0;   // kick spacing, 0 none
    logic [7:0]          oscCnt = 8'h0; // capacitor oscillators
    logic                kick;
    logic                resetNO;
    logic                resetNOe;
    logic                trip;
    logic                resetLine;
    logic                tripSeen;
    int                  err_total = 0;
    int                  n_compared = 0;
    int                  n;             // cycles of last watch

    rsw_supervisor #(.HOLD_SHORT_CYC(20), .HOLD_LONG_CYC(40),
        .RT_CAP_HOLD_TICKS(4), .WD_INT_TICK_CYC(4),
        .FILTER_CYC(5)) DUT (.sys_clk(sys_clk), .srst(srst),
        .supplyCond(cond), .watchdogKickInput(kick),
        .timingStrap(strap), .resetTimingOsc(oscCnt[3]),
        .watchdogTimingOsc(oscCnt[3]), .systemResetNO(resetNO),
        .systemResetNOe(resetNOe), .watchdogTrip(trip));
    rsw_host_model HOST (.sys_clk(sys_clk), .systemResetNOe(resetNOe),
        .kickGap(gap), .watchdogKickInput(kick), .resetLine(resetLine));

    // 25 MHz clock
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    // 16-cycle oscillator period, slow enough for the filter
    always @(negedge sys_clk)
        oscCnt <= oscCnt + 8'h1;

    task automatic check(input bit ok, input string msg);
        n_compared++;
        if (!ok)
        begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // cycles until the enable reads val, at most lim
    task automatic watch(input logic val, input int lim);
        n = 0;
        tripSeen = 1'b0;
        while (n < lim && resetNOe !== val)
        begin
            @(negedge sys_clk);
            n++;
            if (trip === 1'b1)
                tripSeen = 1'b1;
        end
    endtask

    // a wait that must end; a hang closes the run
    task automatic must(input logic val, input int lim);
        watch(val, lim);
        if (n >= lim)
        begin
            check(1'b0, "wait ran out");
            summarize();
        end
    endtask

    // straps taken in lockout, then lockout ends
    task automatic powerUp(input logic [1:0] rs, input logic [1:0] ws,
                           input int lo, input int hi);
        gap = 16'h0;
        srst = 1'b1;
        cond = 4'h9;
        strap = {ws, rs};
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        watch(1'b0, 40);
        check(n == 40, "lockout let reset go");
        cond = 4'h1;
        must(1'b0, 400);
        check(n >= lo && n <= hi, "hold length");
        check(resetLine && !resetNO, "line not released");
        $display("power-up test done, hold %0d", n);
    endtask

    // glitch then real fault on the sense, over and under comparators
    task automatic faults();
        for (int b = 0; b < 3; b++)
        begin
            cond = 4'h1 ^ (4'h1 << b);
            repeat (3) @(negedge sys_clk);
            cond = 4'h1;
            watch(1'b1, 30);
            check(n == 30, "glitch made reset");
            cond = 4'h1 ^ (4'h1 << b);
            must(1'b1, 12);
            check(n <= 10, "fault late");
            repeat (30) @(negedge sys_clk);
            check(resetNOe === 1'b1, "fault not held");
            cond = 4'h1;
            must(1'b0, 60);
            check(n >= 27 && n <= 32, "hold after fault");
        end
        $display("fault test done");
    endtask

    // run, then cycles to a trip with kick spacing g
    task automatic dog(input logic [15:0] g, input int lim,
                       input int lo, input int hi);
        gap = g;
        must(1'b0, 200);
        watch(1'b1, lim);
        check(n >= lo && n <= hi, "trip time");
        check(tripSeen === (n < lim), "trip pulse");
        $display("watchdog test done, %0d cycles", n);
    endtask

    initial
    begin
        powerUp(2'h0, 2'h0, 27, 32);
        faults();
        powerUp(2'h1, 2'h0, 47, 52);
        powerUp(2'h2, 2'h0, 55, 76);
        powerUp(2'h0, 2'h2, 27, 32);
        dog(16'h0, 3000, 2048, 2080);
        dog(16'h0, 3000, 2048, 2080);
        dog(16'h30, 200, 30, 80);
        dog(16'h280, 4000, 4000, 4000);
        powerUp(2'h0, 2'h1, 27, 32);
        faults();
        dog(16'h0, 34000, 32768, 32780);
        dog(16'h320, 1000, 790, 830);
        dog(16'h640, 6000, 6000, 6000);
        summarize();
    end
endmodule
